// >>> src/mmm_consts.vh
// constants of the mii management master: register map, fields, resets
// assumes a 32-bit classic wishbone slave, word addresses in adr[5:2]
`ifndef MMM_CONSTS_VH
`define MMM_CONSTS_VH

// register index in adr[5:2], alias operation in adr[7:6]
`define MMM_IDX_CONFIG     4'h0
`define MMM_IDX_COMMAND    4'h1
`define MMM_IDX_ADDRESS    4'h2
`define MMM_IDX_WRDATA     4'h3
`define MMM_IDX_RDDATA     4'h4
`define MMM_IDX_INDICATOR  4'h5
`define MMM_OP_WRITE       2'h0
`define MMM_OP_CLEAR       2'h1
`define MMM_OP_SET         2'h2
`define MMM_OP_INVERT      2'h3

// implemented bits per register
`define MMM_CONFIG_MASK    32'h0000803f
`define MMM_COMMAND_MASK   32'h00000003
`define MMM_ADDRESS_MASK   32'h00001f1f
`define MMM_WRDATA_MASK    32'h0000ffff

// reset values
`define MMM_CONFIG_RESET   32'h00000020
`define MMM_COMMAND_RESET  32'h00000000
`define MMM_ADDRESS_RESET  32'h00000100

// field positions
`define MMM_CFG_SOFT_RESET 15
`define MMM_CFG_DIV_HI     5
`define MMM_CFG_DIV_LO     2
`define MMM_CFG_PREAMBLE_SUPPRESS      1
`define MMM_CFG_SCAN_ADDRESS_INCREMENT    0
`define MMM_CMD_SCAN       1
`define MMM_CMD_READ       0
`define MMM_ADR_PHY_HI     12
`define MMM_ADR_PHY_LO     8
`define MMM_ADR_REG_HI     4
`define MMM_ADR_REG_LO     0
`define MMM_IND_BUSY       0
`define MMM_IND_SCAN       1
`define MMM_IND_READ_DATA_PENDING   2

// frame layout
`define MMM_PREAMBLE_BITS  6'h1f
`define MMM_FRAME_LAST     6'h1f
`define MMM_OE_READ_LAST   6'h12
`define MMM_DATA_FIRST     6'h0f
`define MMM_START_CODE     2'h1
`define MMM_OPC_READ       2'h2
`define MMM_OPC_WRITE      2'h1
`define MMM_TA_WRITE       2'h2

// mdc half periods in system clocks, for divisors 4..40
`define MMM_HALF_4         5'h02
`define MMM_HALF_6         5'h03
`define MMM_HALF_8         5'h04
`define MMM_HALF_10        5'h05
`define MMM_HALF_14        5'h07
`define MMM_HALF_20        5'h0a
`define MMM_HALF_28        5'h0e
`define MMM_HALF_40        5'h14

`endif

// >>> src/mmm_mdc_div.v
// mdc generator: divides the system clock by the selected divisor
// assumes run is a level on the same clock; ticks are one-cycle pulses
`timescale 1ns/1ps
`include "mmm_consts.vh"

module mmm_mdc_div (
  // clock and reset
  input  wire       clock,
  input  wire       resetn,
  // control
  input  wire       run,
  input  wire [3:0] divSel,
  // mdc and its edge pulses
  output wire       mdc,
  output wire       riseTick,
  output wire       fallTick
);

  reg  [4:0] cnt_q;
  reg        mdc_q;
  reg  [4:0] half;
  wire       wrap;

  // divisor table, undefined codes fall back to the slowest
  always @*
  begin
    case (divSel)
      4'h0, 4'h1: half = `MMM_HALF_4;
      4'h2:       half = `MMM_HALF_6;
      4'h3:       half = `MMM_HALF_8;
      4'h4:       half = `MMM_HALF_10;
      4'h5:       half = `MMM_HALF_14;
      4'h6:       half = `MMM_HALF_20;
      4'h7:       half = `MMM_HALF_28;
      default:    half = `MMM_HALF_40;
    endcase
  end

  assign wrap = (cnt_q >= half - 5'h01);

  always @(posedge clock)
  begin
    if (!resetn || !run)
    begin
      cnt_q <= 5'h00;
      mdc_q <= 1'b0;
    end
    else if (wrap)
    begin
      cnt_q <= 5'h00;
      mdc_q <= ~mdc_q;
    end
    else
    begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  assign mdc      = mdc_q;
  assign riseTick = run & wrap & ~mdc_q;
  assign fallTick = run & wrap & mdc_q;

endmodule // mmm_mdc_div

// >>> src/mmm_master.v
// mii management master with wishbone register file
// assumes mdioIn comes from a pin; wishbone master is on the same clock
`timescale 1ns/1ps
`include "mmm_consts.vh"

module mmm_master (
  // clock and reset
  input  wire        clock,
  input  wire        resetn,
  // wishbone slave
  input  wire        wbCyc,
  input  wire        wbStb,
  input  wire        wbWe,
  input  wire [7:0]  wbAdr,
  input  wire [3:0]  wbSel,
  input  wire [31:0] wbDatIn,
  output reg  [31:0] wbDatOut,
  output reg         wbAck,
  // management pins
  output wire        mdc,
  input  wire        mdioIn,
  output reg         mdioOut,
  output reg         mdioOe
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_PRE   = 2'h1;
  localparam ST_FRAME = 2'h2;

  reg  [31:0] config_q;
  reg  [31:0] command_q;
  reg  [31:0] address_q;
  reg  [15:0] wrData_q;
  reg  [15:0] rdData_q;
  reg         wrPend_q;
  reg         rdPend_q;
  reg         read_data_pending_q;
  reg         scanning_q;
  reg  [4:0]  scanPhy_q;
  reg  [1:0]  state_q;
  reg  [5:0]  bitCnt_q;
  reg  [31:0] frame_q;
  reg         isRead_q;
  reg         isScan_q;
  reg  [15:0] rdShift_q;
  reg         mdioMeta_q;
  reg         mdioSync_q;

  wire        softReset;
  wire        engRstn;
  wire        riseTick;
  wire        fallTick;
  wire        busAccess;
  wire        busWrite;
  wire        laneOk;
  wire [31:0] laneMask;
  wire [1:0]  aliasOp;
  wire [3:0]  regIdx;
  wire        busy;
  wire [4:0]  targetPhy;
  wire [4:0]  targetReg;
  wire [4:0]  framePhy;
  wire        scanReq;
  reg  [31:0] rdMux;

  assign softReset = config_q[`MMM_CFG_SOFT_RESET];
  assign engRstn   = resetn & ~softReset;
  assign targetPhy = address_q[`MMM_ADR_PHY_HI:`MMM_ADR_PHY_LO];
  assign targetReg = address_q[`MMM_ADR_REG_HI:`MMM_ADR_REG_LO];
  assign scanReq   = command_q[`MMM_CMD_SCAN];

  // busy covers launched and queued cycles
  assign busy = (state_q != ST_IDLE) | wrPend_q | rdPend_q;

  // bus decode; write lands on the edge that the master sees ack
  assign busAccess = wbCyc & wbStb;
  assign busWrite  = busAccess & wbWe & wbAck;
  assign aliasOp   = wbAdr[7:6];
  assign regIdx    = wbAdr[5:2];
  assign laneOk    = (wbSel == 4'hf) | (wbSel == 4'h3) | (wbSel == 4'hc);
  assign laneMask  = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};

  // alias update of a stored value
  function [31:0] applyWrite;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [31:0] mask;
    input [1:0]  op;
    reg   [31:0] m;
    begin
      m = newVal & mask;
      case (op)
        `MMM_OP_CLEAR:  applyWrite = oldVal & ~m;
        `MMM_OP_SET:    applyWrite = oldVal | m;
        `MMM_OP_INVERT: applyWrite = oldVal ^ m;
        default:        applyWrite = (oldVal & ~mask) | m;
      endcase
    end
  endfunction

  wire        cfgWr   = busWrite & laneOk & (regIdx == `MMM_IDX_CONFIG);
  wire        cmdWr   = busWrite & laneOk & (regIdx == `MMM_IDX_COMMAND);
  wire        adrWr   = busWrite & laneOk & (regIdx == `MMM_IDX_ADDRESS);
  wire        wdWr    = busWrite & laneOk & (regIdx == `MMM_IDX_WRDATA);
  wire [31:0] cmdNext = applyWrite(command_q, wbDatIn, laneMask, aliasOp)
                        & `MMM_COMMAND_MASK;
  wire [31:0] wdNext  = applyWrite({16'h0000, wrData_q}, wbDatIn, laneMask, aliasOp)
                        & `MMM_WRDATA_MASK;

  // wishbone ack and read data
  always @*
  begin
    case (regIdx)
      `MMM_IDX_CONFIG:    rdMux = config_q;
      `MMM_IDX_COMMAND:   rdMux = command_q;
      `MMM_IDX_ADDRESS:   rdMux = address_q;
      `MMM_IDX_WRDATA:    rdMux = {16'h0000, wrData_q};
      `MMM_IDX_RDDATA:    rdMux = {16'h0000, rdData_q};
      `MMM_IDX_INDICATOR: rdMux = {29'h00000000, read_data_pending_q, scanning_q, busy};
      default:            rdMux = 32'h00000000;
    endcase
  end

  always @(posedge clock)
  begin
    if (!resetn)
    begin
      wbAck    <= 1'b0;
      wbDatOut <= 32'h00000000;
    end
    else
    begin
      wbAck    <= busAccess & ~wbAck;
      wbDatOut <= (busAccess & ~wbAck & ~wbWe) ? rdMux : 32'h00000000;
    end
  end

  // software registers; only implemented bits are stored
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      config_q  <= `MMM_CONFIG_RESET;
      command_q <= `MMM_COMMAND_RESET;
      address_q <= `MMM_ADDRESS_RESET;
      wrData_q  <= 16'h0000;
    end
    else
    begin
      if (cfgWr)
        config_q <= applyWrite(config_q, wbDatIn, laneMask, aliasOp)
                    & `MMM_CONFIG_MASK;
      if (cmdWr)
        command_q <= cmdNext;
      if (adrWr)
        address_q <= applyWrite(address_q, wbDatIn, laneMask, aliasOp)
                     & `MMM_ADDRESS_MASK;
      if (wdWr && !busy)
        wrData_q <= wdNext[15:0];
    end
  end

  // mdio input synchroniser
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      mdioMeta_q <= 1'b0;
      mdioSync_q <= 1'b0;
    end
    else
    begin
      mdioMeta_q <= mdioIn;
      mdioSync_q <= mdioMeta_q;
    end
  end

  mmm_mdc_div uDiv (
    .clock    (clock),
    .resetn   (engRstn),
    .run      (1'b1),
    .divSel   (config_q[`MMM_CFG_DIV_HI:`MMM_CFG_DIV_LO]),
    .mdc      (mdc),
    .riseTick (riseTick),
    .fallTick (fallTick)
  );

  // phy of the next read: scan sweep or the programmed address
  assign framePhy = (wrPend_q | rdPend_q) ? targetPhy : scanPhy_q;

  // frame engine; bits change on mdc fall, phy samples on rise
  always @(posedge clock)
  begin
    if (!engRstn)
    begin
      state_q    <= ST_IDLE;
      bitCnt_q   <= 6'h00;
      frame_q    <= 32'h00000000;
      isRead_q   <= 1'b0;
      isScan_q   <= 1'b0;
      rdShift_q  <= 16'h0000;
      rdData_q   <= 16'h0000;
      wrPend_q   <= 1'b0;
      rdPend_q   <= 1'b0;
      read_data_pending_q <= 1'b0;
      scanning_q <= 1'b0;
      scanPhy_q  <= 5'h01;
      mdioOut    <= 1'b1;
      mdioOe     <= 1'b0;
    end
    else
    begin
      if (!scanReq && state_q == ST_IDLE)
        scanning_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (fallTick && (wrPend_q || rdPend_q || scanReq))
          begin
            isRead_q <= ~wrPend_q;
            isScan_q <= ~wrPend_q & ~rdPend_q;
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            if (!wrPend_q && !rdPend_q)
            begin
              scanning_q <= 1'b1;
              read_data_pending_q <= 1'b1;
            end
            if (wrPend_q)
              frame_q <= {`MMM_START_CODE, `MMM_OPC_WRITE, targetPhy, targetReg,
                          `MMM_TA_WRITE, wrData_q};
            else if (rdPend_q)
              frame_q <= {`MMM_START_CODE, `MMM_OPC_READ, framePhy, targetReg,
                          18'h3ffff};
            else
              frame_q <= {`MMM_START_CODE, `MMM_OPC_READ, framePhy, targetReg,
                          18'h3ffff};
            mdioOe <= 1'b1;
            if (config_q[`MMM_CFG_PREAMBLE_SUPPRESS])
            begin
              state_q  <= ST_FRAME;
              bitCnt_q <= `MMM_FRAME_LAST;
              mdioOut  <= 1'b0;
            end
            else
            begin
              state_q  <= ST_PRE;
              bitCnt_q <= `MMM_PREAMBLE_BITS;
              mdioOut  <= 1'b1;
            end
          end
        end
        ST_PRE:
        begin
          if (fallTick)
          begin
            if (bitCnt_q == 6'h00)
            begin
              state_q  <= ST_FRAME;
              bitCnt_q <= `MMM_FRAME_LAST;
              mdioOut  <= frame_q[31];
            end
            else
            begin
              bitCnt_q <= bitCnt_q - 6'h01;
            end
          end
        end
        ST_FRAME:
        begin
          if (riseTick && isRead_q && bitCnt_q <= `MMM_DATA_FIRST)
            rdShift_q <= {rdShift_q[14:0], mdioSync_q};
          if (fallTick)
          begin
            if (bitCnt_q == 6'h00)
            begin
              state_q <= ST_IDLE;
              mdioOe  <= 1'b0;
              mdioOut <= 1'b1;
              if (isRead_q)
              begin
                rdData_q   <= rdShift_q;
                read_data_pending_q <= rdPend_q;
              end
              if (isScan_q && config_q[`MMM_CFG_SCAN_ADDRESS_INCREMENT])
                scanPhy_q <= (scanPhy_q >= targetPhy) ? 5'h01
                             : scanPhy_q + 5'h01;
              else if (isScan_q)
                scanPhy_q <= targetPhy;
            end
            else
            begin
              bitCnt_q <= bitCnt_q - 6'h01;
              frame_q  <= {frame_q[30:0], 1'b1};
              mdioOut  <= frame_q[30];
              if (isRead_q && bitCnt_q <= `MMM_OE_READ_LAST)
                mdioOe <= 1'b0;
            end
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
      // new commands only while idle; after the case so a set beats a launch
      if (wdWr && !busy)
        wrPend_q <= 1'b1;
      if (cmdWr && !busy && cmdNext[`MMM_CMD_READ] && !command_q[`MMM_CMD_READ])
      begin
        rdPend_q   <= 1'b1;
        read_data_pending_q <= 1'b1;
      end
      // a fresh scan starts at phy 1 or at the fixed target
      if (state_q == ST_IDLE && !scanning_q && !scanReq)
        scanPhy_q <= config_q[`MMM_CFG_SCAN_ADDRESS_INCREMENT] ? 5'h01 : targetPhy;
    end
  end

endmodule // mmm_master

// >>> testbench/mmm_master_sva.sv
// assertions on the management master's bus and pins
// assumes a single clock; bound to every mmm_master
`timescale 1ns/1ps
module mmm_master_sva (
  // clock and reset
  input wire        clock,
  input wire        resetn,
  // wishbone
  input wire        wbCyc,
  input wire        wbStb,
  input wire        wbWe,
  input wire [7:0]  wbAdr,
  input wire [3:0]  wbSel,
  input wire [31:0] wbDatIn,
  input wire [31:0] wbDatOut,
  input wire        wbAck,
  // management pins
  input wire        mdc,
  input wire        mdioIn,
  input wire        mdioOut,
  input wire        mdioOe
);
  reg       softQ;
  reg       lastMdc;
  reg [5:0] stillQ;
  wire      cfgWr = wbCyc && wbStb && wbWe && wbAck && wbAdr[5:2] == 4'h0
                    && (wbSel == 4'hf || wbSel == 4'h3);

  // mirror of the soft reset bit, all alias kinds
  always @(posedge clock)
    if (!resetn)
      softQ <= 1'b0;
    else if (cfgWr)
      case (wbAdr[7:6])
        2'h0:    softQ <= wbDatIn[15];
        2'h1:    softQ <= softQ & ~wbDatIn[15];
        2'h2:    softQ <= softQ | wbDatIn[15];
        default: softQ <= softQ ^ wbDatIn[15];
      endcase

  // cycles since mdc last moved
  always @(posedge clock)
  begin
    lastMdc <= mdc;
    stillQ  <= (!resetn || softQ || mdc != lastMdc) ? 6'h00 : stillQ + 6'h01;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence busReq;
    wbCyc && wbStb && !wbAck;
  endsequence
  sequence mdcRise;
    !mdc ##1 mdc;
  endsequence

  ack_answer_a: assert property (busReq |=> wbAck)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack held too long");
  ack_cause_a: assert property (wbAck |-> $past(wbCyc && wbStb))
    else $error("ack without request");
  upper_zero_a: assert property (wbAck && !wbWe |-> wbDatOut[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  rise_stable_a: assert property (mdcRise |-> $stable(mdioOut))
    else $error("mdio moved at mdc rise");
  mdc_high_a: assert property (mdcRise |=> mdc || softQ)
    else $error("mdc high phase too short");
  soft_hold_a: assert property (softQ && $past(softQ) |-> !mdc && !mdioOe)
    else $error("activity during soft reset");
  mdc_runs_a: assert property (stillQ <= 6'd24)
    else $error("mdc stopped");
  oe_drop_a: assert property ($fell(mdioOe) |-> !mdc)
    else $error("mdio released off mdc fall");
endmodule // mmm_master_sva

bind mmm_master mmm_master_sva i_sva (
  .clock(clock), .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
  .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
  .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe));

// >>> testbench/mmm_phy_model.sv
// phy model on the management pins: answers reads, records frames
// assumes mdc comes from the master; the line has a pull-up
`timescale 1ns/1ps
module mmm_phy_model (
  // management pins
  input  wire        mdc,
  input  wire        mdioOe,
  input  wire        mdioOut,
  output reg         phyOe,
  output reg         phyOut,
  // last frame seen and the number of frames seen
  output reg  [31:0] frame,
  output reg  [6:0]  frameLen,
  output reg  [31:0] frameCnt
);
  reg  [31:0] sh;
  reg  [6:0]  n;
  reg  [4:0]  idx;
  wire [15:0] rdVal = {3'h5, frame[9:0], 3'h3};

  initial
  begin
    {sh, n, idx, phyOe, phyOut, frame, frameLen, frameCnt} = '0;
  end

  // master bits taken on mdc rise
  always @(posedge mdc)
    if (mdioOe)
    begin
      sh <= {sh[30:0], mdioOut};
      n  <= n + 7'h01;
    end
    else
    begin
      if (n != 7'h00)
      begin
        frame    <= sh;
        frameLen <= n;
        frameCnt <= frameCnt + 32'h1;
      end
      // read header, with or without preamble
      if (sh[13:10] == 4'h6 && (n == 7'd14 || n == 7'd46))
        idx <= 5'h01;
      else if (idx != 5'h00 && idx < 5'd18)
        idx <= idx + 5'h01;
      else
        idx <= 5'h00;
      sh <= 32'h0;
      n  <= 7'h00;
    end

  // turnaround zero then data, changed on mdc fall
  always @(negedge mdc)
  begin
    phyOe  <= idx != 5'h00 && idx < 5'd18;
    phyOut <= (idx < 5'd2 || idx > 5'd17) ? 1'b0 : rdVal[5'd17 - idx];
  end
endmodule // mmm_phy_model

// >>> testbench/mmm_master_test.sv
// self-checking bench for the management master with a phy model
// assumes the checker binds itself; 200 MHz clock
`timescale 1ns/1ps
module mmm_master_test;
  reg         clock   = 1'b0;
  reg         resetn  = 1'b0;
  reg         wbCyc   = 1'b0;
  reg         wbStb   = 1'b0;
  reg         wbWe    = 1'b0;
  reg  [7:0]  wbAdr   = 8'h00;
  reg  [3:0]  wbSel   = 4'h0;
  reg  [31:0] wbDatIn = 32'h0;
  reg  [31:0] q;
  wire [31:0] wbDatOut;
  wire        wbAck, mdc, mdioOut, mdioOe, phyOe, phyOut;
  wire [31:0] frame, frameCnt;
  wire [6:0]  frameLen;
  wire        mdioIn = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);
  integer     errorCnt = 0, totalChecks = 0, i, j, c, f0;
  integer     divs [0:8] = '{4, 4, 6, 8, 10, 14, 20, 28, 40};

  always #2.5 clock = ~clock;

  mmm_master i_dut (.clock(clock), .resetn(resetn), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe));
  mmm_phy_model i_phy (.mdc(mdc), .mdioOe(mdioOe), .mdioOut(mdioOut), .phyOe(phyOe),
    .phyOut(phyOut), .frame(frame), .frameLen(frameLen), .frameCnt(frameCnt));

  task automatic conclude;
    begin
      $display("checks %0d errors %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task automatic stuck;
    begin
      errorCnt = errorCnt + 1;
      conclude;
    end
  endtask

  task automatic chk(input [31:0] got, input [31:0] exp);
    begin
      totalChecks = totalChecks + 1;
      if (got !== exp)
      begin
        errorCnt = errorCnt + 1;
        $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task automatic wb(input [7:0] a, input w, input [31:0] d, input [3:0] s);
    integer n;
    begin
      @(posedge clock);
      wbCyc   <= 1'b1;
      wbStb   <= 1'b1;
      wbWe    <= w;
      wbAdr   <= a;
      wbSel   <= s;
      wbDatIn <= d;
      n = 0;
      do
      begin
        @(posedge clock);
        n = n + 1;
      end
      while (wbAck !== 1'b1 && n < 50);
      q = wbDatOut;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (n >= 50)
        stuck;
    end
  endtask

  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s = 4'hf);
    wb(a, 1'b1, d, s);
  endtask

  task automatic rd(input [7:0] a);
    wb(a, 1'b0, 32'h0, 4'hf);
  endtask

  task automatic wrChk(input [7:0] a, input [31:0] d, input [3:0] s, input [31:0] e);
    begin
      wr(a, d, s);
      rd({2'h0, a[5:0]});
      chk(q, e);
    end
  endtask

  task automatic waitIdle(input [31:0] m);
    integer n;
    begin
      n = 0;
      do
      begin
        rd(8'h14);
        n = n + 1;
      end
      while ((q & m) != 0 && n < 3000);
      if (n >= 3000)
        stuck;
    end
  endtask

  task automatic waitFrame;
    integer n, f;
    begin
      n = 0;
      f = frameCnt;
      while (frameCnt == f && n < 6000)
      begin
        @(posedge clock);
        n = n + 1;
      end
      if (n >= 6000)
        stuck;
    end
  endtask

  // clocks between two mdc rises
  task automatic mdcRise;
    reg p;
    begin
      c = 0;
      do
      begin
        p = mdc;
        @(posedge clock);
        c = c + 1;
      end
      while (!(p === 1'b0 && mdc === 1'b1) && c < 100);
      if (c >= 100)
        stuck;
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    rd(8'h00);
    chk(q, 32'h20);
    rd(8'h04);
    chk(q, 32'h0);
    rd(8'h08);
    chk(q, 32'h100);
    rd(8'h18);
    chk(q, 32'h0);
    wrChk(8'h08, 32'hffffffff, 4'hf, 32'h1f1f);
    wrChk(8'h08, 32'h0, 4'h1, 32'h1f1f);
    wrChk(8'h48, 32'h1c1c, 4'hf, 32'h0303);
    wrChk(8'h88, 32'h0400, 4'h3, 32'h0703);
    wrChk(8'hc8, 32'h0101, 4'hf, 32'h0602);
    wrChk(8'h00, 32'hffffffff, 4'hf, 32'h803f);
    for (i = 0; i < 9; i = i + 1)
    begin
      wr(8'h00, {26'h0, i[3:0], 2'h0});
      mdcRise;
      mdcRise;
      mdcRise;
      chk(c, divs[i]);
    end
    // write frame, second write while busy
    wr(8'h00, 32'h1a);
    wr(8'h08, 32'h0305);
    f0 = frameCnt;
    wr(8'h0c, 32'ha5c3);
    rd(8'h14);
    chk(q & 32'h1, 32'h1);
    wr(8'h0c, 32'h1111);
    waitIdle(32'h1);
    repeat (20) @(posedge clock);
    chk(frameCnt - f0, 32'h1);
    chk(frame, {2'h1, 2'h1, 5'h03, 5'h05, 2'h2, 16'ha5c3});
    chk({25'h0, frameLen}, 32'd32);
    // read frame with preamble
    wr(8'h00, 32'h18);
    wr(8'h08, 32'h0407);
    wr(8'h04, 32'h1);
    repeat (10) @(posedge clock);
    rd(8'h14);
    chk(q & 32'h5, 32'h5);
    waitIdle(32'h1);
    chk(q & 32'h4, 32'h0);
    rd(8'h10);
    chk(q, {16'h0, 3'h5, 5'h04, 5'h07, 3'h3});
    chk(frame, {18'h3ffff, 2'h1, 2'h2, 5'h04, 5'h07});
    chk({25'h0, frameLen}, 32'd46);
    wr(8'h04, 32'h0);
    // scan with and without increment
    wr(8'h08, 32'h0201);
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(8'h00, {26'h0, 4'h6, 1'b1, i == 0});
      wr(8'h04, 32'h2);
      for (j = 0; j < 3; j = j + 1)
      begin
        waitFrame;
        chk({27'h0, frame[9:5]}, (i == 0 && j != 1) ? 32'h1 : 32'h2);
      end
      rd(8'h14);
      chk(q & 32'h2, 32'h2);
      wr(8'h04, 32'h0);
      waitIdle(32'h3);
    end
    // soft reset with a write still queued
    wr(8'h0c, 32'h5a5a);
    wr(8'h00, 32'h801a);
    rd(8'h14);
    chk(q & 32'h3, 32'h0);
    wr(8'h00, 32'h1a);
    conclude;
  end
endmodule // mmm_master_test
